// *** rtl/serial_link_consts.svh ***
`ifndef SERIAL_LINK_CONSTS_SVH
`define SERIAL_LINK_CONSTS_SVH
// Clock rate and oversampling
`define CLK_HZ 50000000
`define OVERSAMPLE 16
// Register byte addresses
`define REG_CTRL 8'h00
`define REG_TXDATA 8'h04
`define REG_RXDATA 8'h08
`define REG_STATUS 8'h0C
`define REG_TRIG 8'h10
// Control register fields
`define CF_BAUD 3:0
`define CF_SEVEN 4
`define CF_PAR 6:5
`define CF_TWOSTOP 7
`define CF_FLOW 9:8
`define CF_ENABLE 10
`define CF_RESTART 11
// Status register fields
`define ST_RXERR 3
`define ST_TRIG 5
// Reset values: 115.2k, 8 data bits, no parity, 1 stop, no flow, enabled
`define CTRL_RESET 32'h00000408
`define TRIG_RESET 8'h54
// Field encodings
`define PAR_EVEN 2'h1
`define PAR_ODD 2'h2
`define FLOW_SW 2'h1
`define FLOW_ACK 2'h2
// In-band control characters
`define CH_XOFF 8'h13
`define CH_XON 8'h11
`define CH_ACK 8'h06
`define CH_NAK 8'h15
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** rtl/serial_link_pkg.sv ***
package serial_link_pkg;
    // Transmitter sequencing
    typedef enum logic [0:0] {TX_IDLE, TX_SEND} tx_state_type;
    // Receiver sequencing
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_type;
endpackage

// *** rtl/byte_stream_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// Valid/ready stream between the port logic and its buffer
interface byte_stream_if #(parameter int WIDTH = 8);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    // Buffer side
    modport store (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    // Port logic side
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// *** rtl/two_entry_buffer.sv ***
`timescale 1ns/10ps
`default_nettype none
module two_entry_buffer #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Stream
    byte_stream_if.store bs
);
    logic [WIDTH-1:0] mem [2]; // Storage words
    logic head; // Read slot
    logic tail; // Write slot
    logic [1:0] count; // Words held
    wire push = bs.in_valid && bs.in_ready;
    wire pop = bs.out_valid && bs.out_ready;

    assign bs.in_ready = (count != 2'h2);
    assign bs.out_valid = (count != 2'h0);
    assign bs.out_data = mem[head];

    ////////////////////////////////////////////////////////////////
    // Pointers and count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            head <= 1'b0;
            tail <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                tail <= ~tail;
            end
            if (pop) begin
                head <= ~head;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    // Data store
    always_ff @(posedge aclk) begin
        if (push) begin
            mem[tail] <= bs.in_data;
        end
    end
endmodule
`default_nettype wire

// *** rtl/reader_serial_port_link.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "serial_link_consts.svh"
module reader_serial_port_link import serial_link_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus write channels
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Register bus read channels
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Serial pins
    output logic serial_tx_line,
    input wire logic serial_rx_line,
    // Read command seen
    output logic read_trigger
);
    ////////////////////////////////////////////////////////////////
    // Helpers
    // Clock cycles per oversample tick for a rate index
    function automatic logic [12:0] tick_div(input logic [3:0] sel);
        int unsigned baud;
        case (sel)
            4'h0: baud = 600;
            4'h1: baud = 1200;
            4'h2: baud = 2400;
            4'h3: baud = 4800;
            4'h4: baud = 9600;
            4'h5: baud = 19200;
            4'h6: baud = 38400;
            4'h7: baud = 57600;
            4'h9: baud = 230400;
            default: baud = 115200;
        endcase
        tick_div = 13'(`CLK_HZ / (baud * `OVERSAMPLE));
    endfunction

    // Parity bit making the chosen count of ones
    function automatic logic par_bit(input logic [7:0] d, input logic [1:0] mode);
        par_bit = (mode == `PAR_ODD) ? ~(^d) : ^d;
    endfunction

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = (old & ~m) | (nw & m);
    endfunction

    ////////////////////////////////////////////////////////////////
    // Configuration
    logic [31:0] ctrl; // Control register
    logic [7:0] trig_char; // Read command character
    logic port_active; // Enable in force since last restart
    wire seven = ctrl[`CF_SEVEN];
    wire [1:0] par_mode = ctrl[`CF_PAR];
    wire par_en = (par_mode == `PAR_EVEN) || (par_mode == `PAR_ODD);
    wire two_stop = ctrl[`CF_TWOSTOP];
    wire flow_sw = (ctrl[`CF_FLOW] == `FLOW_SW);
    wire ack_mode = (ctrl[`CF_FLOW] == `FLOW_ACK);
    wire [3:0] nd = seven ? 4'h7 : 4'h8;
    // frame length: start bit, data bits, parity bit if enabled, and one or two stop bits
    wire [3:0] frame_len = 4'h1 + nd + {3'h0, par_en} + (two_stop ? 4'h2 : 4'h1);
    wire [3:0] rx_need = frame_len - 4'h1;

    ////////////////////////////////////////////////////////////////
    // Oversample tick divider
    logic [12:0] tick_cnt; // Divider count
    wire [12:0] cur_div = tick_div(ctrl[`CF_BAUD]);
    wire tick = (tick_cnt >= cur_div - 13'h1);

    // Free-running tick enable
    always_ff @(posedge aclk) begin
        if (!aresetn || tick) begin
            tick_cnt <= 13'h0;
        end else begin
            tick_cnt <= tick_cnt + 13'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Receiver
    logic [2:0] rx_sync; // Pin synchroniser
    logic rx_level; // Filtered line level
    logic rx_prev; // Filtered level one cycle back, idles high so reset makes no edge
    rx_state_type rx_state; // Receive sequencing
    logic [3:0] rx_sub; // Tick within bit
    logic [3:0] rx_idx; // Bit within frame
    logic [10:0] rx_bits; // Collected bits
    wire rx_last = (rx_state == RX_BITS) && tick && (rx_sub == 4'hF);
    wire rx_done = rx_last && (rx_idx == rx_need - 4'h1) && port_active;
    wire [10:0] rx_full = rx_bits | (11'(rx_level) << rx_idx);
    wire [7:0] rx_data = seven ? {1'b0, rx_full[6:0]} : rx_full[7:0];
    wire [3:0] stop_pos = nd + {3'h0, par_en};
    wire stop_ok = rx_full[stop_pos] && (!two_stop || rx_full[stop_pos + 4'h1]);
    wire par_ok = !par_en || (rx_full[nd] == par_bit(rx_data, par_mode));
    wire rx_bad = !(par_ok && stop_ok);

    // Three-stage pin synchroniser, change counts when last two agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_sync <= 3'h7;
            rx_level <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_sync <= {rx_sync[1:0], serial_rx_line};
            rx_prev <= rx_level;
            if (rx_sync[1] == rx_sync[2]) begin
                rx_level <= rx_sync[2];
            end
        end
    end

    // start bit checked mid-bit, then LSB-first sampling
    always_ff @(posedge aclk) begin
        if (!aresetn || !port_active) begin
            rx_state <= RX_IDLE;
            rx_sub <= 4'h0;
            rx_idx <= 4'h0;
            rx_bits <= 11'h0;
        end else begin
            case (rx_state)
                // Wait for falling edge
                RX_IDLE: begin
                    rx_sub <= 4'h0;
                    rx_idx <= 4'h0;
                    rx_bits <= 11'h0;
                    // A held-low line after a bad stop must not restart the receiver
                    if (rx_prev && !rx_level) begin
                        rx_state <= RX_START;
                    end
                end
                // Half a bit into the start bit
                RX_START: begin
                    if (tick) begin
                        rx_sub <= rx_sub + 4'h1;
                        if (rx_sub == 4'h7) begin
                            rx_sub <= 4'h0;
                            rx_state <= rx_level ? RX_IDLE : RX_BITS;
                        end
                    end
                end
                // One sample per bit time
                RX_BITS: begin
                    if (tick) begin
                        rx_sub <= rx_sub + 4'h1;
                    end
                    if (rx_last) begin
                        rx_bits <= rx_full;
                        rx_idx <= rx_idx + 4'h1;
                        if (rx_idx == rx_need - 4'h1) begin
                            rx_state <= RX_IDLE;
                        end
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Received character handling
    logic await_ack; // Data character awaiting its answer
    logic paused; // Pause character received
    logic [7:0] rx_hold; // Character for software
    logic rx_valid; // Holding register full
    logic rx_err; // Sticky reception error
    logic trig_seen; // Sticky read command seen
    logic ctrl_pend; // Answer character to send
    logic [7:0] ctrl_char; // Which answer
    logic sent_xoff; // Pause sent, resume owed
    // controls are interpreted only in their own modes
    wire is_flow = flow_sw && !rx_bad && (rx_data == `CH_XOFF || rx_data == `CH_XON);
    wire is_resp = ack_mode && await_ack && !rx_bad
                   && (rx_data == `CH_ACK || rx_data == `CH_NAK);
    wire ack_got = rx_done && is_resp && (rx_data == `CH_ACK);
    wire nak_got = rx_done && is_resp && (rx_data == `CH_NAK);
    wire deliver = rx_done && !rx_bad && !is_flow && !is_resp;
    wire reply_req = rx_done && ack_mode && !is_resp;

    ////////////////////////////////////////////////////////////////
    // Transmitter
    byte_stream_if #(.WIDTH(8)) tbuf ();
    tx_state_type tx_state; // Transmit sequencing
    logic [11:0] tx_shift; // Frame being sent
    logic [3:0] tx_left; // Bits still to send
    logic [3:0] tx_sub; // Tick within bit
    logic [7:0] tx_char; // Character being sent
    wire tx_idle = (tx_state == TX_IDLE) && port_active;
    // pause while receive space is used up
    wire want_xoff = flow_sw && rx_valid && !sent_xoff;
    wire want_xon = flow_sw && !rx_valid && sent_xoff;
    wire start_ctrl = tx_idle && (want_xoff || want_xon || ctrl_pend);
    wire data_ok = tbuf.out_valid && !await_ack && !(flow_sw && paused);
    // result string leaves from the buffer in order
    wire start_data = tx_idle && !(want_xoff || want_xon || ctrl_pend) && data_ok;
    wire [7:0] next_char = want_xoff ? `CH_XOFF : want_xon ? `CH_XON
                         : ctrl_pend ? ctrl_char : tbuf.out_data;
    wire [11:0] next_frame = {3'h7, seven ? {par_en ? par_bit({1'b0, next_char[6:0]}, par_mode)
                             : 1'b1, next_char[6:0]} : next_char, 1'b0}
                             & ~(12'(!seven && par_en) << 9)
                             | (12'(!seven && par_en && par_bit(next_char, par_mode)) << 9);
    // head word leaves the buffer when its frame starts, or in answer mode only on a positive answer
    assign tbuf.out_ready = (start_data && !ack_mode) || ack_got;

    two_entry_buffer #(.WIDTH(8)) tx_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .bs(tbuf)
    );

    // frame shifted out LSB first, line idles high
    // a disabled port abandons its frame
    always_ff @(posedge aclk) begin
        if (!aresetn || !port_active) begin
            tx_state <= TX_IDLE;
            tx_shift <= 12'hFFF;
            tx_left <= 4'h0;
            tx_sub <= 4'h0;
            tx_char <= 8'h00;
            serial_tx_line <= 1'b1;
        end else begin
            serial_tx_line <= (tx_state == TX_SEND) ? tx_shift[0] : 1'b1;
            if (start_ctrl || start_data) begin
                tx_state <= TX_SEND;
                tx_shift <= next_frame;
                tx_left <= frame_len;
                tx_sub <= 4'h0;
                tx_char <= next_char;
            end else if (tx_state == TX_SEND && tick) begin
                tx_sub <= tx_sub + 4'h1;
                if (tx_sub == 4'hF) begin
                    tx_shift <= {1'b1, tx_shift[11:1]};
                    tx_left <= tx_left - 4'h1;
                    if (tx_left == 4'h1) begin
                        tx_state <= TX_IDLE;
                    end
                end
            end
        end
    end

    // Flow and answer state; a set in the same cycle wins over a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            await_ack <= 1'b0;
            paused <= 1'b0;
            ctrl_pend <= 1'b0;
            ctrl_char <= `CH_ACK;
            sent_xoff <= 1'b0;
        end else begin
            // answer ends the wait, a refusal leaves the word to resend
            await_ack <= (start_data && ack_mode) || (await_ack && !ack_got && !nak_got);
            // pause character halts data, resume releases it
            if (!flow_sw || (rx_done && is_flow && rx_data == `CH_XON)) begin
                paused <= 1'b0;
            end else if (rx_done && is_flow) begin
                paused <= 1'b1;
            end
            // good reception answered, bad answered negatively
            if (reply_req) begin
                ctrl_pend <= 1'b1;
                ctrl_char <= rx_bad ? `CH_NAK : `CH_ACK;
            end else if (start_ctrl && !want_xoff && !want_xon) begin
                ctrl_pend <= 1'b0;
            end
            if (!flow_sw || (start_ctrl && want_xon)) begin
                sent_xoff <= 1'b0;
            end else if (start_ctrl && want_xoff) begin
                sent_xoff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Register bus slave
    wire wr_is_tx = (awaddr == `REG_TXDATA);
    wire wr_go = awvalid && wvalid && !bvalid && !(wr_is_tx && !tbuf.in_ready);
    wire wr_known = (awaddr == `REG_CTRL) || wr_is_tx || (awaddr == `REG_STATUS)
                    || (awaddr == `REG_TRIG);
    wire wr_ctrl = wr_go && (awaddr == `REG_CTRL);
    wire w1c_st = wr_go && (awaddr == `REG_STATUS);
    wire rd_go = arvalid && !rvalid;
    wire rd_known = (araddr == `REG_CTRL) || (araddr == `REG_TXDATA)
                    || (araddr == `REG_RXDATA) || (araddr == `REG_STATUS)
                    || (araddr == `REG_TRIG);
    wire rd_pop = rd_go && (araddr == `REG_RXDATA);
    wire [31:0] status_word = {24'h0, await_ack, port_active, trig_seen, 1'b0,
                               rx_err, paused, rx_valid,
                               (tx_state != TX_IDLE) || tbuf.out_valid};
    wire [31:0] rd_word = (araddr == `REG_CTRL) ? ctrl
                        : (araddr == `REG_RXDATA) ? {23'h0, rx_valid, rx_hold}
                        : (araddr == `REG_STATUS) ? status_word
                        : (araddr == `REG_TRIG) ? {24'h0, trig_char} : 32'h0;
    wire hit_trig = deliver && (rx_data == trig_char);
    assign awready = wr_go;
    assign wready = wr_go;
    assign arready = rd_go;
    // Software pushes into the transmit buffer; a full buffer stalls the write
    assign tbuf.in_valid = wr_go && wr_is_tx && wstrb[0];
    assign tbuf.in_data = wdata[7:0];

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `RESP_OKAY;
        end else if (rd_go) begin
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `CTRL_RESET;
            trig_char <= `TRIG_RESET;
            port_active <= 1'b1;
        end else begin
            if (wr_ctrl) begin
                ctrl <= merge(ctrl, wdata, wstrb) & ~(32'h1 << `CF_RESTART);
            end
            // read command character written by software
            if (wr_go && awaddr == `REG_TRIG && wstrb[0]) begin
                trig_char <= wdata[7:0];
            end
            // enable setting takes hold only on restart
            if (wr_ctrl && wstrb[1] && wdata[`CF_RESTART]) begin
                port_active <= wdata[`CF_ENABLE];
            end
        end
    end

    // Received data, sticky flags and trigger pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_hold <= 8'h00;
            rx_valid <= 1'b0;
            rx_err <= 1'b0;
            trig_seen <= 1'b0;
            read_trigger <= 1'b0;
        end else begin
            if (deliver) begin
                rx_hold <= rx_data;
            end
            rx_valid <= deliver || (rx_valid && !rd_pop);
            rx_err <= (rx_done && rx_bad) || (rx_err && !(w1c_st && wdata[`ST_RXERR]));
            trig_seen <= hit_trig || (trig_seen && !(w1c_st && wdata[`ST_TRIG]));
            read_trigger <= hit_trig;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_disabled_idle: assert property (!port_active |=> ##1 serial_tx_line)
        else $error("Disabled port drove the line low");
    a_start_low: assert property ((start_ctrl || start_data) |=> ##1 !serial_tx_line)
        else $error("Frame did not begin with a low start bit");
    a_frame_len: assert property ((start_ctrl || start_data) |=> tx_left == frame_len)
        else $error("Frame length does not match data, parity and stop settings");
    a_tick_bound: assert property ($stable(cur_div) |-> tick_cnt < cur_div)
        else $error("Rate divider overran its period");
    a_pause_data: assert property ((flow_sw && paused) |-> !start_data)
        else $error("Data sent while paused");
    a_xoff_sent: assert property ((tx_idle && want_xoff) |=> tx_char == `CH_XOFF)
        else $error("Pause character not sent");
    a_xon_sent: assert property ((tx_idle && want_xon) |=> tx_char == `CH_XON)
        else $error("Resume character not sent");
    a_plain_quiet: assert property ((ctrl[`CF_FLOW] == 2'h0) |-> !start_ctrl)
        else $error("Control character sent in plain mode");
    a_ack_reply: assert property ((reply_req && !rx_bad) |=> ctrl_pend && ctrl_char == `CH_ACK)
        else $error("Good reception not answered");
    a_nak_reply: assert property ((reply_req && rx_bad) |=> ctrl_pend && ctrl_char == `CH_NAK)
        else $error("Failed reception not answered negatively");
    a_nak_resend: assert property (nak_got |-> !tbuf.out_ready ##1 tbuf.out_valid)
        else $error("Refused word dropped");
    a_rx_error: assert property ((rx_done && rx_bad) |=> rx_err)
        else $error("Parity or stop error not flagged");
    a_trigger: assert property (hit_trig |=> read_trigger && trig_seen)
        else $error("Read command not signalled");

    c_data_sent: cover property (start_data);
    c_nak_seen: cover property (nak_got);
    c_pause: cover property (rx_done && is_flow);
    c_trigger: cover property (read_trigger);
endmodule
`default_nettype wire

// *** testbench/host_uart_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Host end of the serial link at the bench bit rate
module host_uart_model #(parameter int BIT = 208) (
    // Clock and serial pins
    input wire logic aclk,
    input wire logic serial_tx_line,
    output logic serial_rx_line
);
    logic [7:0] got[$]; // Characters seen from the device
    initial serial_rx_line = 1'b1;
    // start low, LSB first, chosen stop level
    task send(input logic [7:0] b, input logic stp);
        logic [9:0] f;
        f = {stp, b, 1'b0};
        for (int k = 0; k < 10; k++) begin
            serial_rx_line <= f[k];
            repeat (BIT) @(posedge aclk);
        end
        serial_rx_line <= 1'b1;
        repeat (BIT) @(posedge aclk);
    endtask
    // mid-bit sampling, unknown kept on a bad stop
    always begin : rx
        logic [7:0] v;
        @(negedge serial_tx_line);
        repeat (BIT / 2) @(posedge aclk);
        for (int k = 0; k < 8; k++) begin
            repeat (BIT) @(posedge aclk);
            v[k] = serial_tx_line;
        end
        repeat (BIT) @(posedge aclk);
        got.push_back(serial_tx_line ? v : 8'hXX);
    end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, tx, rx, trig;
    int n_fail = 0;
    int checked = 0;
    int n_trig = 0;
    // Count read command pulses
    always @(posedge aclk) if (trig === 1'b1) n_trig++;
    always #10 aclk = ~aclk;
    reader_serial_port_link uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .serial_tx_line(tx),
        .serial_rx_line(rx), .read_trigger(trig));
    host_uart_model host (.aclk(aclk), .serial_tx_line(tx), .serial_rx_line(rx));
    // Verdict and end of run
    task results;
        if (n_fail == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    // One clock of a bounded wait
    task tick(input int i);
        @(posedge aclk);
        if (i > 9999) begin
            n_fail++;
            results;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        i = 0;
        do tick(i++); while (!awready);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        do tick(i++); while (!bvalid);
        bready <= 1'b0;
        r = bresp;
    endtask
    // Read, mask and compare
    task chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        int i;
        araddr <= a;
        arvalid <= 1'b1;
        i = 0;
        do tick(i++); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do tick(i++); while (!rvalid);
        rready <= 1'b0;
        v = rdata;
        r = rresp;
        cmp(v & m, e);
    endtask
    // Next character at the host
    task rxb(input logic [7:0] e);
        int i;
        i = 0;
        while (host.got.size() == 0) tick(i++);
        cmp({24'h0, host.got.pop_front()}, {24'h0, e});
    endtask
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        chk(8'h00, 32'hFFFFFFFF, 32'h00000408);
        chk(8'h10, 32'hFF, 32'h54);
        wr(8'h00, 32'h00000409);
        wr(8'h04, 32'h41);
        wr(8'h04, 32'h5A);
        wr(8'h04, 32'hA5);
        rxb(8'h41);
        rxb(8'h5A);
        rxb(8'hA5);
        host.send(8'h3C, 1'b1);
        chk(8'h08, 32'h1FF, 32'h13C);
        wr(8'h10, 32'h71);
        host.send(8'h71, 1'b1);
        chk(8'h0C, 32'h20, 32'h20);
        cmp(n_trig, 32'h1);
        host.send(8'h13, 1'b1);
        chk(8'h08, 32'h1FF, 32'h113);
        wr(8'h00, 32'h000004B9);
        wr(8'h04, 32'h43);
        rxb(8'hC3);
        host.send(8'hC3, 1'b1);
        chk(8'h08, 32'h1FF, 32'h143);
        wr(8'h00, 32'h00000009);
        chk(8'h0C, 32'h40, 32'h40);
        wr(8'h00, 32'h00000509);
        host.send(8'h22, 1'b1);
        rxb(8'h13);
        chk(8'h08, 32'h1FF, 32'h122);
        rxb(8'h11);
        host.send(8'h13, 1'b1);
        wr(8'h04, 32'h55);
        repeat (3000) @(posedge aclk);
        cmp(32'(host.got.size()), 32'h0);
        host.send(8'h11, 1'b1);
        rxb(8'h55);
        wr(8'h00, 32'h00000609);
        host.send(8'h33, 1'b1);
        rxb(8'h06);
        chk(8'h08, 32'h1FF, 32'h133);
        host.send(8'h34, 1'b0);
        rxb(8'h15);
        chk(8'h0C, 32'h08, 32'h08);
        wr(8'h04, 32'h44);
        rxb(8'h44);
        host.send(8'h15, 1'b1);
        rxb(8'h44);
        host.send(8'h06, 1'b1);
        chk(8'h0C, 32'h80, 32'h0);
        wr(8'h00, 32'h00000809);
        chk(8'h0C, 32'h40, 32'h0);
        wr(8'h04, 32'h66);
        repeat (3000) @(posedge aclk);
        cmp(32'(host.got.size()), 32'h0);
        wr(8'h40, 32'h0);
        cmp({30'h0, r}, 32'h2);
        chk(8'h40, 32'hFFFFFFFF, 32'h0);
        cmp({30'h0, r}, 32'h2);
        results;
    end
endmodule
`default_nettype wire
